/* logic/loopback_nibble_mem.sv */
`timescale 1ns/100ps

module loopback_nibble_mem #(
  parameter int WIDTH = 4,
  parameter int WORDS = 8,
  parameter int AW    = 3
) (
  // Clock
  input  wire logic             mclk,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] store_reg [WORDS];

  if (WORDS > (1 << AW)) begin : g_check
    $error("loopback_nibble_mem: WORDS exceeds address range");
  end

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      store_reg[wr_addr] <= wr_data;
    end
  end

  // Registered read data
  always_ff @(posedge mclk) begin
    if (rd_en) begin
      rd_data <= store_reg[rd_addr];
    end
  end

endmodule : loopback_nibble_mem

/* logic/phy_ctrl_pkg.sv */
package phy_ctrl_pkg;

  // ==========================================
  // Register map (byte address is four times the index)
  localparam logic [7:0]  POWER_MODE_CTRL_INDEX = 8'h11;
  localparam logic [7:0]  POWER_MODE_CTRL_ADDR  = 8'h44;

  // ==========================================
  // Field positions
  localparam int CLOCK_OFF_BIT       = 15;
  localparam int POWER_SAVE_ENABLE_BIT       = 14;
  localparam int PS_SELECT_HI        = 13;
  localparam int PS_SELECT_LO        = 12;
  localparam int SCRAMBLER_BYPASS_BIT = 11;
  localparam int FIFO_DEPTH_HI       = 9;
  localparam int FIFO_DEPTH_LO       = 8;
  localparam int FD_COLLISION_BIT    = 4;

  // Writable bits; reserved 10 and 7:5 (and unbuilt 3:0) stay zero
  localparam logic [15:0] CTRL_WRITE_MASK = 16'hFB10;

  // ==========================================
  // Reset values
  localparam logic [15:0] CTRL_RESET      = 16'h0100;

  // ==========================================
  // Power-save select codes
  localparam logic [1:0]  PS_NORMAL       = 2'h0;
  localparam logic [1:0]  PS_MGMT_ONLY    = 2'h1;
  localparam logic [1:0]  PS_ACTIVE_SLEEP = 2'h2;
  localparam logic [1:0]  PS_PASSIVE_SLEEP = 2'h3;

  // ==========================================
  // Loopback FIFO depths in nibbles
  localparam logic [3:0]  DEPTH_CODE0     = 4'h4;
  localparam logic [3:0]  DEPTH_CODE1     = 4'h5;
  localparam logic [3:0]  DEPTH_CODE2     = 4'h6;
  localparam logic [3:0]  DEPTH_CODE3     = 4'h8;
  localparam int          FIFO_WORDS      = 8;

  // ==========================================
  // Timing
  localparam int          CLOCK_HZ          = 10_000_000;
  localparam int          NLP_PERIOD_MS     = 1400;
  localparam int          NLP_PERIOD_CYCLES = NLP_PERIOD_MS * (CLOCK_HZ / 1000);

endpackage : phy_ctrl_pkg

/* logic/phy_power_and_mode_control.sv */
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps

// What this block does
// - Bit 15 set switches off internal clock generation; resets to zero.
// - Clock shutdown only acts in management-only power-down mode.
// - Bit 14 enables power-save modes; zero keeps normal operation; resets zero.
// - Select field 13:12 resets to 00; 00 keeps everything fully active.
// - Select 01 powers down all but the management interface.
// - Select 10 is active sleep; energy detect wakes the device automatically.
// - Active sleep sends a link pulse every 1.4 seconds.
// - Select 11 is passive sleep; no pulses; energy detect wakes device.
// - Bit 11 bypasses the 100 Mb/s scrambler; resets to zero.
// - Reserved bits 10 and 7:5 ignore writes and read zero.
// - Field 9:8 sets loopback FIFO depth 4,5,6,8 nibbles; resets to 01.
// - Far-end loopback data passes through the rate-matching FIFO.
// - Bit 4 enables collision signalling in full duplex; resets zero.
module phy_power_and_mode_control #(
  parameter int NLP_PERIOD = phy_ctrl_pkg::NLP_PERIOD_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Line status
  input  wire logic        energy_detect,
  input  wire logic        full_duplex,
  input  wire logic        collision_detect,
  // Far-end loopback path
  input  wire logic        loopback_enable,
  input  wire logic [3:0]  rx_nibble,
  input  wire logic        rx_nibble_valid,
  input  wire logic        tx_nibble_tick,
  output logic      [3:0]  tx_nibble,
  output logic             tx_nibble_valid,
  // Power and datapath controls
  output logic             clock_gen_off,
  output logic             core_power_down,
  output logic             energy_detect_on,
  output logic             nlp_pulse,
  output logic             scrambler_bypass,
  output logic             collision_out
);

  // ==========================================
  // Elaboration checks
  if (NLP_PERIOD < 2) begin : g_check
    $error("phy_power_and_mode_control: NLP_PERIOD too small");
  end

  // ==========================================
  // Decode helpers
  function automatic logic [1:0] effective_mode(input logic [15:0] ctrl);
    if (ctrl[phy_ctrl_pkg::POWER_SAVE_ENABLE_BIT]) begin
      effective_mode = ctrl[phy_ctrl_pkg::PS_SELECT_HI:phy_ctrl_pkg::PS_SELECT_LO];
    end else begin
      effective_mode = phy_ctrl_pkg::PS_NORMAL;
    end
  endfunction : effective_mode

  function automatic logic [3:0] depth_of(input logic [1:0] code);
    unique case (code)
      2'h0: depth_of = phy_ctrl_pkg::DEPTH_CODE0;
      2'h1: depth_of = phy_ctrl_pkg::DEPTH_CODE1;
      2'h2: depth_of = phy_ctrl_pkg::DEPTH_CODE2;
      2'h3: depth_of = phy_ctrl_pkg::DEPTH_CODE3;
    endcase
  endfunction : depth_of

  // ==========================================
  // Bus handshake
  logic        ctrl_hit;
  logic        bus_take;
  logic [15:0] ctrl_reg;
  logic [15:0] wr_lanes;
  logic [15:0] ctrl_written;
  logic [1:0]  mode_now;
  logic        sleeping;

  assign ctrl_hit     = (avs_address == phy_ctrl_pkg::POWER_MODE_CTRL_ADDR);
  assign bus_take     = (avs_read || avs_write) && !avs_waitrequest;
  assign wr_lanes     = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}} & phy_ctrl_pkg::CTRL_WRITE_MASK;
  assign ctrl_written = (ctrl_reg & ~wr_lanes) | (avs_writedata[15:0] & wr_lanes);
  assign mode_now     = effective_mode(ctrl_reg);
  assign sleeping     = (mode_now == phy_ctrl_pkg::PS_ACTIVE_SLEEP) ||
                        (mode_now == phy_ctrl_pkg::PS_PASSIVE_SLEEP);

  // One wait cycle, then the request is taken with waitrequest low
  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if (bus_take) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Read data prepared in the wait cycle; unmapped reads give zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= ctrl_hit ? {16'h0000, ctrl_reg & phy_ctrl_pkg::CTRL_WRITE_MASK} : 32'h0000_0000;
    end
  end

  // ==========================================
  // Control register
  // A software write beats a wake in the same cycle: it is the newer intent.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_reg <= phy_ctrl_pkg::CTRL_RESET;
    end else if (bus_take && avs_write && ctrl_hit) begin
      ctrl_reg <= ctrl_written;
    end else if (sleeping && energy_detect) begin
      ctrl_reg[phy_ctrl_pkg::POWER_SAVE_ENABLE_BIT] <= 1'b0;
    end
  end

  // ==========================================
  // Power state outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      core_power_down <= 1'b0;
      clock_gen_off   <= 1'b0;
      energy_detect_on <= 1'b0;
    end else begin
      core_power_down  <= (mode_now != phy_ctrl_pkg::PS_NORMAL);
      clock_gen_off    <= ctrl_reg[phy_ctrl_pkg::CLOCK_OFF_BIT] &&
                          (mode_now == phy_ctrl_pkg::PS_MGMT_ONLY);
      energy_detect_on <= sleeping;
    end
  end

  wake_pulse_timer #(
    .PERIOD (NLP_PERIOD)
  ) u_wake_timer (
    .mclk  (mclk),
    .rst   (rst),
    .run   (mode_now == phy_ctrl_pkg::PS_ACTIVE_SLEEP),
    .pulse (nlp_pulse)
  );

  // ==========================================
  // Datapath controls
  always_ff @(posedge mclk) begin
    if (rst) begin
      scrambler_bypass <= 1'b0;
      collision_out    <= 1'b0;
    end else begin
      scrambler_bypass <= ctrl_reg[phy_ctrl_pkg::SCRAMBLER_BYPASS_BIT];
      collision_out    <= collision_detect &&
                          (!full_duplex || ctrl_reg[phy_ctrl_pkg::FD_COLLISION_BIT]);
    end
  end

  // ==========================================
  // Far-end loopback FIFO
  logic [2:0] wr_ptr_reg;
  logic [2:0] rd_ptr_reg;
  logic [3:0] fill_reg;
  logic       draining_reg;
  logic       push;
  logic       pop;
  logic [3:0] depth_now;

  assign depth_now = depth_of(ctrl_reg[phy_ctrl_pkg::FIFO_DEPTH_HI:phy_ctrl_pkg::FIFO_DEPTH_LO]);
  // Overflow drops nibbles: the depth setting is software's to size right
  assign push = loopback_enable && rx_nibble_valid && (fill_reg != 4'(phy_ctrl_pkg::FIFO_WORDS));
  assign pop  = loopback_enable && draining_reg && tx_nibble_tick && (fill_reg != 4'h0);

  loopback_nibble_mem #(
    .WIDTH (4),
    .WORDS (phy_ctrl_pkg::FIFO_WORDS),
    .AW    (3)
  ) u_fifo_mem (
    .mclk    (mclk),
    .wr_en   (push),
    .wr_addr (wr_ptr_reg),
    .wr_data (rx_nibble),
    .rd_en   (pop),
    .rd_addr (rd_ptr_reg),
    .rd_data (tx_nibble)
  );

  always_ff @(posedge mclk) begin
    if (rst || !loopback_enable) begin
      wr_ptr_reg <= 3'h0;
      rd_ptr_reg <= 3'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 3'h1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !loopback_enable) begin
      fill_reg <= 4'h0;
    end else if (push && !pop) begin
      fill_reg <= fill_reg + 4'h1;
    end else if (pop && !push) begin
      fill_reg <= fill_reg - 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !loopback_enable) begin
      draining_reg <= 1'b0;
    end else if (!draining_reg && fill_reg >= depth_now) begin
      draining_reg <= 1'b1;
    end else if (draining_reg && fill_reg == 4'h0) begin
      draining_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_nibble_valid <= 1'b0;
    end else begin
      tx_nibble_valid <= pop;
    end
  end

  // ==========================================
  // Checks
  // Bus answer timing: one wait cycle, one taking cycle
  a_wait_one_cycle: assert property (@(posedge mclk) disable iff (rst)
    $rose(avs_read) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest did not drop for exactly one cycle");

  a_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
    ctrl_reg[10] == 1'b0 && ctrl_reg[7:5] == 3'h0)
    else $error("reserved control bits became nonzero");

  a_clock_off_gated: assert property (@(posedge mclk) disable iff (rst)
    clock_gen_off |-> $past(mode_now) == phy_ctrl_pkg::PS_MGMT_ONLY)
    else $error("clock shutdown outside management-only mode");

  a_clock_off_follows: assert property (@(posedge mclk) disable iff (rst)
    ctrl_reg[15] && mode_now == phy_ctrl_pkg::PS_MGMT_ONLY |=> clock_gen_off)
    else $error("clock shutdown not applied");

  a_enable_gates: assert property (@(posedge mclk) disable iff (rst)
    !ctrl_reg[phy_ctrl_pkg::POWER_SAVE_ENABLE_BIT] |=> !core_power_down)
    else $error("power down without enable");

  a_mode_powers_down: assert property (@(posedge mclk) disable iff (rst)
    mode_now != phy_ctrl_pkg::PS_NORMAL |=> core_power_down)
    else $error("power-save mode did not power down core");

  a_sleep_detects: assert property (@(posedge mclk) disable iff (rst)
    sleeping |=> energy_detect_on)
    else $error("energy detection off during sleep");

  a_sleep_wakes: assert property (@(posedge mclk) disable iff (rst)
    sleeping && energy_detect && !(bus_take && avs_write) |=> !ctrl_reg[phy_ctrl_pkg::POWER_SAVE_ENABLE_BIT])
    else $error("energy detect did not wake device");

  a_no_pulse_passive: assert property (@(posedge mclk) disable iff (rst)
    mode_now != phy_ctrl_pkg::PS_ACTIVE_SLEEP |=> !nlp_pulse)
    else $error("wake pulse outside active sleep");

  a_collision_fd: assert property (@(posedge mclk) disable iff (rst)
    full_duplex && !ctrl_reg[phy_ctrl_pkg::FD_COLLISION_BIT] |=> !collision_out)
    else $error("collision signalled in full duplex while disabled");

  a_scrambler_bypass: assert property (@(posedge mclk) disable iff (rst)
    scrambler_bypass == $past(ctrl_reg[phy_ctrl_pkg::SCRAMBLER_BYPASS_BIT]))
    else $error("scrambler bypass does not follow control bit");

  a_fifo_prefill: assert property (@(posedge mclk) disable iff (rst)
    $rose(draining_reg) |-> $past(fill_reg) >= $past(depth_now))
    else $error("loopback drain began before depth reached");

  a_fifo_bound: assert property (@(posedge mclk) disable iff (rst)
    fill_reg <= 4'(phy_ctrl_pkg::FIFO_WORDS))
    else $error("loopback fill exceeds storage");

endmodule : phy_power_and_mode_control

/* logic/wake_pulse_timer.sv */
`timescale 1ns/100ps

module wake_pulse_timer #(
  parameter int PERIOD = 14_000_000
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Control
  input  wire logic run,
  output logic      pulse
);

  localparam int CW = $clog2(PERIOD);

  logic [CW-1:0] count_reg;

  if (PERIOD < 2) begin : g_check
    $error("wake_pulse_timer: PERIOD must be at least 2");
  end

  // Restarts from zero whenever the sleep state is left
  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      count_reg <= '0;
    end else if (count_reg == CW'(PERIOD - 1)) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      pulse <= 1'b0;
    end else begin
      pulse <= (count_reg == CW'(PERIOD - 1));
    end
  end

endmodule : wake_pulse_timer

/* test/mgmt_master.sv */
`timescale 1ns/100ps

// ==========================================
// Station management side: one Avalon-MM transfer at a time
module mgmt_master (
  // Clock
  input  wire logic        mclk,
  // Request
  output logic      [7:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  // Answer
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial begin
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'h0;
  end

  // Held until waitrequest is seen low; released lines show inverted values
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    @(posedge mclk);
    avs_address    <= a;
    avs_read       <= !wr;
    avs_write      <= wr;
    avs_writedata  <= {16'h0000, d};
    avs_byteenable <= be;
    // Only the bench timeout ends a wait that never completes
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read       <= 1'b0;
    avs_write      <= 1'b0;
    avs_address    <= ~a;
    avs_writedata  <= {16'hFFFF, ~d};
  endtask : xfer
endmodule : mgmt_master

/* test/tb_phy_power_and_mode_control.sv */
`timescale 1ns/100ps

module tb_phy_power_and_mode_control;
  // ==========================================
  // Signals
  logic        mclk             = 1'b0;
  logic        rst              = 1'b1;
  logic        energy_detect    = 1'b0;
  logic        full_duplex      = 1'b0;
  logic        collision_detect = 1'b0;
  logic        loopback_enable  = 1'b0;
  logic [3:0]  rx_nibble        = 4'h0;
  logic        rx_nibble_valid  = 1'b0;
  logic        tx_nibble_tick   = 1'b0;
  logic [7:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable, tx_nibble;
  logic        tx_nibble_valid, clock_gen_off, core_power_down, energy_detect_on;
  logic        nlp_pulse, scrambler_bypass, collision_out;
  logic [31:0] q;
  int          error_cnt  = 0;
  int          n_compared = 0;
  int          cyc        = 0;
  int          n;

  // Output view: clock off, power down, energy detect, scrambler bypass
  wire logic [3:0] outs = {clock_gen_off, core_power_down, energy_detect_on, scrambler_bypass};

  typedef struct packed {
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [3:0]  outs;
  } row_type;

  // Loopback depths per select code
  localparam logic [3:0] DEPTHS [4] = '{phy_ctrl_pkg::DEPTH_CODE0, phy_ctrl_pkg::DEPTH_CODE1,
                                        phy_ctrl_pkg::DEPTH_CODE2, phy_ctrl_pkg::DEPTH_CODE3};

  localparam row_type ROWS [10] = '{
    '{16'h5000, 16'h5000, 4'h4}, '{16'hD000, 16'hD000, 4'hC}, '{16'h9000, 16'h9000, 4'h0},
    '{16'h6000, 16'h6000, 4'h6}, '{16'h7000, 16'h7000, 4'h6}, '{16'h4000, 16'h4000, 4'h0},
    '{16'h0800, 16'h0800, 4'h1}, '{16'hFFFF, 16'hFB10, 4'h7}, '{16'h04E0, 16'h0000, 4'h0},
    '{16'h0300, 16'h0300, 4'h0}};

  always #50 mclk = ~mclk;

  phy_power_and_mode_control #(.NLP_PERIOD(20)) uut (
    .mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .energy_detect, .full_duplex, .collision_detect,
    .loopback_enable, .rx_nibble, .rx_nibble_valid, .tx_nibble_tick, .tx_nibble,
    .tx_nibble_valid, .clock_gen_off, .core_power_down, .energy_detect_on, .nlp_pulse,
    .scrambler_bypass, .collision_out);

  mgmt_master mgr (
    .mclk, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest);

  // ==========================================
  // Checking and bus helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] d);
    logic [31:0] r;
    mgr.xfer(1'b1, 8'h44, d, 4'hF, r);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    mgr.xfer(1'b0, a, 16'h0000, 4'hF, r);
    chk(r, exp);
  endtask : rdchk

  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle

  // One transmit slot, then look just after the answering edge
  task automatic slot_tick();
    @(posedge mclk);
    tx_nibble_tick <= 1'b1;
    @(posedge mclk);
    tx_nibble_tick <= 1'b0;
    #1;
  endtask : slot_tick

  task automatic end_of_test();
    if (error_cnt == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // Hang guard well above the few hundred cycles needed
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rdchk(8'h44, 32'h0000_0100);
    chk(32'({outs, nlp_pulse, collision_out}), 32'h0);
    foreach (ROWS[i]) begin
      wr(ROWS[i].wdata);
      settle();
      chk(32'(outs), 32'(ROWS[i].outs));
      rdchk(8'h44, 32'(ROWS[i].rdata));
    end
    // Pulse count over a window of five periods
    for (int m = 0; m < 2; m++) begin
      wr(m == 0 ? 16'h6000 : 16'h7000);
      repeat (10) @(posedge mclk);
      n = 0;
      repeat (100) begin
        @(posedge mclk);
        if (nlp_pulse === 1'b1)
          n++;
      end
      chk(32'(n), m == 0 ? 32'd5 : 32'd0);
      @(posedge mclk);
      energy_detect <= 1'b1;
      repeat (3) @(posedge mclk);
      energy_detect <= 1'b0;
      settle();
      chk(32'(core_power_down), 32'h0);
      rdchk(8'h44, m == 0 ? 32'h2000 : 32'h3000);
    end
    for (int i = 0; i < 4; i++) begin
      wr(i[1] ? 16'h0010 : 16'h0000);
      @(posedge mclk);
      full_duplex      <= i[0];
      collision_detect <= 1'b1;
      settle();
      chk(32'(collision_out), 32'(!i[0] || i[1]));
    end
    @(posedge mclk);
    collision_detect <= 1'b0;
    wr(16'h0000);
    mgr.xfer(1'b1, 8'h48, 16'hFFFF, 4'hF, q);
    rdchk(8'h48, 32'h0);
    rdchk(8'h44, 32'h0);
    mgr.xfer(1'b1, 8'h44, 16'hFFFF, 4'h1, q);
    rdchk(8'h44, 32'h0010);
    // every depth in turn, each frame kept within it
    for (int d = 0; d < 4; d++) begin
      wr(16'(d << 8));
      @(posedge mclk);
      loopback_enable <= 1'b1;
      for (int i = 0; i < DEPTHS[d]; i++) begin
        // One nibble short of the depth: no drain yet
        if (i == DEPTHS[d] - 1) begin
          @(posedge mclk);
          rx_nibble_valid <= 1'b0;
          slot_tick();
          chk(32'(tx_nibble_valid), 32'h0);
        end
        @(posedge mclk);
        rx_nibble       <= 4'(i + 1);
        rx_nibble_valid <= 1'b1;
      end
      @(posedge mclk);
      rx_nibble_valid <= 1'b0;
      repeat (2) @(posedge mclk);
      for (int i = 0; i <= DEPTHS[d]; i++) begin
        slot_tick();
        chk(32'(tx_nibble_valid), 32'(i < DEPTHS[d]));
        if (i < DEPTHS[d])
          chk(32'(tx_nibble), 32'(i + 1));
      end
      @(posedge mclk);
      loopback_enable <= 1'b0;
    end
    wr(16'hD000);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rdchk(8'h44, 32'h0000_0100);
    chk(32'(outs), 32'h0);
    end_of_test();
  end
endmodule : tb_phy_power_and_mode_control
